// ---- verilog/mrm_pkg.sv ----
// package: constants, encodings and carriers for the remote mode control block
package mrm_pkg;
	// command characters
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_O = 8'h4f;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_M = 8'h4d;
	localparam logic [7:0] CH_V = 8'h56;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_Z = 8'h5a;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_K = 8'h4b;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_TWO = 8'h32;
	localparam logic [7:0] CH_HALT = 8'h25;
	localparam logic [7:0] CH_RESET = 8'h2a;
	localparam logic [7:0] CH_TERM = 8'h0a;
	localparam logic [7:0] CH_TRIG = 8'h3f;
	// numeric limits
	localparam logic [7:0] DEC_BASE = 8'h0a;
	localparam logic [4:0] NUM_SAT = 5'h1f;
	localparam logic [4:0] S_MAX = 5'h11;
	localparam logic [4:0] S_LOW_MAX = 5'h09;
	localparam logic [4:0] S_DEF = 5'h07;
	localparam logic [4:0] S_AVG = 5'h0a;
	localparam logic [4:0] H_BASE = 5'h08;
	localparam logic [4:0] AC_SUB_MAX = 5'h02;
	localparam logic [4:0] FLT_CODE_MAX = 5'h03;
	localparam logic [1:0] DIG_ONE = 2'h1;
	localparam logic [2:0] RANGE_10V = 3'h2;
	// error codes, two bcd digits
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_CMD = 8'h08;
	localparam logic [7:0] ERR_AC_MOM = 8'h09;
	// apb map
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_ERR = 12'h008;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SRST_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	// continuous-trigger command buffer
	localparam int BUF_DEPTH = 16;
	localparam int BUF_AW = 4;
	// trigger modes, bit 0 means continuous
	localparam logic [1:0] TRG_SGL = 2'h0;
	localparam logic [1:0] TRG_CONT = 2'h1;
	localparam logic [1:0] TRG_SGL_ALT = 2'h2;
	localparam logic [1:0] TRG_CONT_ALT = 2'h3;

	typedef enum logic [2:0] {FN_DCV = 3'b000, FN_OHM = 3'b001, FN_DCA = 3'b010,
		FN_ACN = 3'b100, FN_ACE = 3'b101, FN_ACH = 3'b110} mrm_func_e;
	typedef enum logic [2:0] {FL_OFF = 3'b000, FL_STD = 3'b001, FL_ONE = 3'b010,
		FL_TWO = 3'b011, FL_THREE = 3'b100} mrm_filt_e;
	typedef enum logic [3:0] {OP_NONE = 4'h0, OP_S = 4'h1, OP_H = 4'h2, OP_F = 4'h3,
		OP_O = 4'h4, OP_T = 4'h5, OP_M = 4'h6, OP_V = 4'h7, OP_VA = 4'h8, OP_C = 4'h9,
		OP_Z = 4'ha, OP_I = 4'hb, OP_K = 4'hc} mrm_op_e;

	typedef struct packed {
		mrm_func_e func;
		logic dc_cpl;
		logic [4:0] sample;
		mrm_filt_e filt;
		logic avg;
		logic [1:0] trig;
		logic gain_inh;
		logic zero_on;
		logic msg_prog;
	} mrm_mode_s;

	localparam mrm_mode_s MODE_RST = '{func: FN_DCV, dc_cpl: 1'b0, sample: S_DEF,
		filt: FL_OFF, avg: 1'b0, trig: TRG_SGL, gain_inh: 1'b0, zero_on: 1'b1,
		msg_prog: 1'b0};
	localparam int MODE_W = $bits(mrm_mode_s);
endpackage

// ---- verilog/mrm_mode_ctrl.sv ----
// remote command interpreter holding sample, filter, averaging, trigger and correction modes
// Summary of operation
// - S takes 0..17, above 17 is error 08
// - H takes one digit, maps onto S8..S17
// - ac volts refuses every sample change
// - in ac, S0/S1/S2 pick ac sub-function
// - averaging allows standard or two, others cancel
// - ac volts allows only filter off or standard
// - continuous trigger: reset and halt immediate, others buffered
// - no command examined while reading pending; halt discards
// - halt leaves continuous, replays terminated buffered commands
// - averaging on sets S10, standard filter
// - averaging off or change between dc functions: S7, filter off
// - S0..S9 under averaging cancels it, filter off
// - ac-to-ac keeps all, ac-to-dc sets S7
// - ac averaging toggles extended resolution; refusals momentary
// - binary digit 8 only on 10V dc
// - limits error returns programmed message or 2
// - ascii digit 7 zero with five-and-half digits
// - gain correction applies unless inhibited
// - zero commands switch zero mode, no capture
// - reset turns zero on, clears temporary zeros
// - cal mode decides which zeros the commands gate
`timescale 1ns/10ps
module mrm_mode_ctrl
	import mrm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_char_i,
	output logic cmd_ready_o,
	output logic rdg_req_o,
	input wire logic rdg_done_i,
	output logic rdg_abort_o,
	input wire logic limit_fail_i,
	input wire logic six_half_i,
	input wire logic [2:0] range_i,
	input wire logic cal_mode_i,
	output mrm_mode_s mode_o,
	output logic err_pulse_o,
	output logic err_resp_prog_o,
	output logic [7:0] err_resp_char_o,
	output logic ascii_d7_zero_o,
	output logic bin_d8_keep_o,
	output logic gain_apply_o,
	output logic perm_zero_apply_o,
	output logic tmp_zero_apply_o,
	output logic tmp_zero_clr_o
);
	logic rst_q1_r, rstn_s;
	mrm_mode_s mode_r, mode_nxt, ex_m;
	mrm_op_e op_r, op_nxt, new_op;
	logic [4:0] num_r, num_nxt;
	logic [1:0] ndig_r, ndig_nxt;
	logic [7:0] err_code_r;
	logic [1:0] ctrl_r;
	logic pend_r;
	logic [7:0] buf_mem [BUF_DEPTH];
	logic [BUF_AW:0] wp_r, term_r, rp_r, rcnt_r;
	logic err_pulse_r, prog_r, d7z_r, d8k_r, gain_r, pz_r, tz_r, tzc_r;
	logic [7:0] echar_r;
	logic [31:0] prdata_r;

	// synchronised reset release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_q1_r <= 1'b0;
			rstn_s <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rstn_s <= rst_q1_r;
		end
	end

	// character source: replay of buffered commands has priority over the port
	wire replaying = (rcnt_r != '0);
	// replay stalls while a replayed trigger still waits for its reading
	wire replay_go = replaying & !pend_r;
	wire [7:0] c = replaying ? buf_mem[rp_r[BUF_AW-1:0]] : cmd_char_i;
	wire is_halt = (cmd_char_i == CH_HALT);
	wire is_rst = (cmd_char_i == CH_RESET);
	wire is_cont = mode_r.trig[0];
	wire is_ac = mode_r.func[2];
	assign cmd_ready_o = ctrl_r[CTRL_EN_BIT] & !replaying & (!pend_r | is_halt | is_rst);
	wire port_take = cmd_valid_i & cmd_ready_o;
	wire halt_in = port_take & is_halt;
	wire rst_in = port_take & is_rst;
	wire buf_in = port_take & !is_halt & !is_rst & is_cont;
	wire buf_full = (wp_r == BUF_DEPTH[BUF_AW:0]);
	wire proc = replay_go | (port_take & !is_halt & !is_rst & !is_cont);
	wire is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
	wire [3:0] dig = 4'(c - CH_ZERO);
	wire is_term = (c == CH_TERM) || (c == CH_TRIG);
	wire takes_dig = (op_r != OP_NONE) && (op_r != OP_V) && (op_r != OP_Z) && (op_r != OP_I);
	wire accum = proc & is_digit & takes_dig;
	wire to_va = proc & (op_r == OP_V) & (c == CH_A);
	wire flush = proc & !accum & !to_va;
	// wide enough that a saturated value times ten cannot wrap below the limit
	wire [9:0] acc_w = {5'h0, num_r} * {2'h0, DEC_BASE} + {6'h0, dig};
	wire [4:0] acc_sat = (acc_w > {5'h0, NUM_SAT}) ? NUM_SAT : acc_w[4:0];
	wire trig_req = flush & (c == CH_TRIG) & !is_cont;
	wire cont_req = is_cont & !pend_r & !halt_in & ctrl_r[CTRL_EN_BIT];
	wire req = trig_req | cont_req;
	wire srst = ctrl_r[CTRL_SRST_BIT];

	always_comb begin
		unique case (c)
			CH_S: new_op = OP_S;
			CH_H: new_op = OP_H;
			CH_F: new_op = OP_F;
			CH_O: new_op = OP_O;
			CH_T: new_op = OP_T;
			CH_M: new_op = OP_M;
			CH_V: new_op = OP_V;
			CH_C: new_op = OP_C;
			CH_Z: new_op = OP_Z;
			CH_I: new_op = OP_I;
			CH_K: new_op = OP_K;
			default: new_op = OP_NONE;
		endcase
	end

	// execution of one completed command against the present mode
	logic ex_bad, ex_mom, fc;
	logic [4:0] sval;
	mrm_func_e nf;
	mrm_filt_e fsel;
	always_comb begin
		ex_m = mode_r;
		ex_bad = 1'b0;
		ex_mom = 1'b0;
		fc = 1'b0;
		nf = FN_DCV;
		sval = (op_r == OP_H) ? 5'(H_BASE + num_r) : num_r;
		unique case (num_r[1:0])
			2'h0: fsel = FL_OFF;
			2'h1: fsel = FL_ONE;
			2'h2: fsel = FL_TWO;
			default: fsel = FL_THREE;
		endcase
		if (ndig_r == '0)
			fsel = FL_STD;
		unique case (op_r)
			OP_S, OP_H: begin
				if (ndig_r == '0 || (op_r == OP_H && ndig_r != DIG_ONE) || sval > S_MAX) begin
					ex_bad = 1'b1;
				end else if (is_ac) begin
					if (op_r == OP_S && num_r <= AC_SUB_MAX)
						ex_m.func = mrm_func_e'({1'b1, num_r[1:0]});
					else
						ex_mom = 1'b1;
				end else begin
					ex_m.sample = sval;
					if (mode_r.avg && sval <= S_LOW_MAX) begin
						ex_m.avg = 1'b0;
						ex_m.filt = FL_OFF;
					end
				end
			end
			OP_F: begin
				if (ndig_r > DIG_ONE || num_r > FLT_CODE_MAX) begin
					ex_bad = 1'b1;
				end else if (is_ac) begin
					if (fsel == FL_OFF || fsel == FL_STD)
						ex_m.filt = fsel;
					else
						ex_mom = 1'b1;
				end else begin
					ex_m.filt = fsel;
					if (mode_r.avg && fsel != FL_STD && fsel != FL_TWO) begin
						ex_m.avg = 1'b0;
						ex_m.sample = S_DEF;
					end
				end
			end
			OP_O: begin
				if (ndig_r == '0) begin
					ex_m.avg = 1'b1;
					if (!is_ac) begin
						ex_m.sample = S_AVG;
						ex_m.filt = FL_STD;
					end
				end else if (ndig_r == DIG_ONE && num_r == '0) begin
					ex_m.avg = 1'b0;
					if (!is_ac) begin
						ex_m.sample = S_DEF;
						ex_m.filt = FL_OFF;
					end
				end else begin
					ex_bad = 1'b1;
				end
			end
			OP_T: begin
				if (ndig_r == '0)
					ex_m.trig = TRG_CONT;
				else if (num_r == 5'h0)
					ex_m.trig = TRG_SGL;
				else if (num_r == 5'h1)
					ex_m.trig = TRG_CONT_ALT;
				else if (num_r == 5'h2)
					ex_m.trig = TRG_SGL_ALT;
				else
					ex_bad = 1'b1;
			end
			OP_M: begin
				if (ndig_r == '0)
					ex_m.gain_inh = 1'b1;
				else if (num_r == 5'h0)
					ex_m.gain_inh = 1'b0;
				else if (num_r == 5'h1)
					ex_m.zero_on = 1'b0;
				else if (num_r == 5'h2)
					ex_m.zero_on = 1'b1;
				else
					ex_bad = 1'b1;
			end
			OP_K: begin
				// only the error-message program form is handled here
				if (ndig_r == DIG_ONE && num_r == 5'h3)
					ex_m.msg_prog = 1'b1;
			end
			OP_V, OP_Z, OP_I: begin
				fc = 1'b1;
				nf = (op_r == OP_V) ? FN_DCV : ((op_r == OP_Z) ? FN_OHM : FN_DCA);
			end
			OP_VA, OP_C: begin
				if (ndig_r > DIG_ONE || num_r > AC_SUB_MAX) begin
					ex_bad = 1'b1;
				end else begin
					fc = 1'b1;
					nf = mrm_func_e'({1'b1, num_r[1:0]});
					ex_m.dc_cpl = (op_r == OP_C);
				end
			end
			default: ;
		endcase
		if (fc) begin
			ex_m.func = nf;
			if (!nf[2]) begin
				ex_m.avg = 1'b0;
				ex_m.sample = S_DEF;
				if (!is_ac)
					ex_m.filt = FL_OFF;
			end else if (!is_ac) begin
				ex_m.avg = 1'b0;
				ex_m.filt = FL_OFF;
			end
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		op_nxt = op_r;
		num_nxt = num_r;
		ndig_nxt = ndig_r;
		if (accum) begin
			num_nxt = acc_sat;
			ndig_nxt = (ndig_r == '1) ? ndig_r : 2'(ndig_r + DIG_ONE);
		end else if (to_va) begin
			op_nxt = OP_VA;
		end else if (flush) begin
			mode_nxt = ex_m;
			op_nxt = is_term ? OP_NONE : new_op;
			num_nxt = '0;
			ndig_nxt = '0;
		end
		if (halt_in)
			mode_nxt.trig = mode_r.trig & ~TRG_CONT;
		if (rst_in || srst) begin
			mode_nxt = MODE_RST;
			op_nxt = OP_NONE;
			num_nxt = '0;
			ndig_nxt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_s) begin
		if (!rstn_s) begin
			mode_r <= MODE_RST;
			op_r <= OP_NONE;
			num_r <= '0;
			ndig_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			op_r <= op_nxt;
			num_r <= num_nxt;
			ndig_r <= ndig_nxt;
		end
	end

	// pending reading and halt discard
	always_ff @(posedge clk_i or negedge rstn_s) begin
		if (!rstn_s)
			pend_r <= 1'b0;
		else if (halt_in || rst_in)
			pend_r <= 1'b0;
		else if (req)
			pend_r <= 1'b1;
		else if (rdg_done_i)
			pend_r <= 1'b0;
	end
	assign rdg_req_o = req & !pend_r;
	assign rdg_abort_o = halt_in & pend_r;

	// command buffer for continuous trigger; chars after the last terminator are dropped
	always_ff @(posedge clk_i) begin
		if (buf_in && !buf_full)
			buf_mem[wp_r[BUF_AW-1:0]] <= cmd_char_i;
	end
	always_ff @(posedge clk_i or negedge rstn_s) begin
		if (!rstn_s) begin
			wp_r <= '0;
			term_r <= '0;
			rp_r <= '0;
			rcnt_r <= '0;
		end else if (rst_in || srst) begin
			wp_r <= '0;
			term_r <= '0;
			rcnt_r <= '0;
		end else if (halt_in && is_cont) begin
			rcnt_r <= term_r;
			rp_r <= '0;
			wp_r <= '0;
			term_r <= '0;
		end else if (replay_go) begin
			rp_r <= rp_r + 1'b1;
			rcnt_r <= rcnt_r - 1'b1;
		end else if (buf_in && !buf_full) begin
			wp_r <= wp_r + 1'b1;
			if (cmd_char_i == CH_TERM || cmd_char_i == CH_TRIG)
				term_r <= wp_r + 1'b1;
		end
	end

	// apb slave, zero wait states; read data captured in the setup phase
	wire setup = psel_i & !penable_i;
	wire access = psel_i & penable_i;
	wire hit_ctrl = (paddr_i == OFS_CTRL);
	wire hit_stat = (paddr_i == OFS_STAT);
	wire hit_err = (paddr_i == OFS_ERR);
	wire hit_any = hit_ctrl | hit_stat | hit_err;
	wire err_clr = access & pwrite_i & hit_err;
	wire err_set = flush & (ex_bad | ex_mom);
	wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
		(hit_stat ? {{(32 - MODE_W){1'b0}}, mode_r} :
		(hit_err ? {24'h0, err_code_r} : 32'h0));
	assign pready_o = 1'b1;
	assign pslverr_o = access & !hit_any;
	assign prdata_o = prdata_r;

	always_ff @(posedge clk_i or negedge rstn_s) begin
		if (!rstn_s) begin
			ctrl_r <= CTRL_RST;
			err_code_r <= ERR_NONE;
			prdata_r <= '0;
		end else begin
			if (setup)
				prdata_r <= rd_mux;
			if (access && pwrite_i && hit_ctrl)
				ctrl_r <= pwdata_i[1:0];
			else
				ctrl_r[CTRL_SRST_BIT] <= 1'b0;
			// a new error wins over a same-cycle clear
			if (err_set)
				err_code_r <= ex_bad ? ERR_CMD : ERR_AC_MOM;
			else if (err_clr)
				err_code_r <= ERR_NONE;
		end
	end

	// reading format and correction steering
	always_ff @(posedge clk_i or negedge rstn_s) begin
		if (!rstn_s) begin
			err_pulse_r <= 1'b0;
			prog_r <= 1'b0;
			echar_r <= CH_TWO;
			d7z_r <= 1'b0;
			d8k_r <= 1'b0;
			gain_r <= 1'b1;
			pz_r <= 1'b1;
			tz_r <= 1'b0;
			tzc_r <= 1'b1;
		end else begin
			err_pulse_r <= err_set;
			prog_r <= limit_fail_i & mode_r.msg_prog;
			echar_r <= CH_TWO;
			d7z_r <= !six_half_i;
			d8k_r <= (mode_r.func == FN_DCV) && (range_i == RANGE_10V)
				&& (mode_r.avg || cal_mode_i);
			gain_r <= !mode_r.gain_inh;
			pz_r <= !cal_mode_i || mode_r.zero_on;
			tz_r <= !cal_mode_i && mode_r.zero_on
				&& (mode_r.func == FN_DCV || mode_r.func == FN_OHM);
			tzc_r <= rst_in || srst;
		end
	end
	assign mode_o = mode_r;
	assign err_pulse_o = err_pulse_r;
	assign err_resp_prog_o = prog_r;
	assign err_resp_char_o = echar_r;
	assign ascii_d7_zero_o = d7z_r;
	assign bin_d8_keep_o = d8k_r;
	assign gain_apply_o = gain_r;
	assign perm_zero_apply_o = pz_r;
	assign tmp_zero_apply_o = tz_r;
	assign tmp_zero_clr_o = tzc_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_s);

	sequence halt_in_cont;
		halt_in && is_cont && !srst;
	endsequence
	sequence left_cont;
		!mode_r.trig[0] && rcnt_r == $past(term_r);
	endsequence

	a_sample_range: assert property (mode_r.sample <= S_MAX)
		else $error("sample setting above limit");
	a_h_mapping: assert property (flush && op_r == OP_H && ndig_r == DIG_ONE && !is_ac
		&& !rst_in && !srst |=> mode_r.sample == 5'(H_BASE + $past(num_r)))
		else $error("alternate sample digit mapped wrong");
	a_ac_sample_lock: assert property (is_ac && $past(is_ac) && !$past(rst_in)
		&& !$past(srst) |-> mode_r.sample == $past(mode_r.sample))
		else $error("sample changed in ac volts");
	a_ac_sub_select: assert property (flush && op_r == OP_S && is_ac && ndig_r == DIG_ONE
		&& num_r <= AC_SUB_MAX && !rst_in && !srst
		|=> mode_r.func[1:0] == $past(num_r[1:0]) && $stable(mode_r.dc_cpl))
		else $error("ac sub-function not selected");
	a_avg_filters: assert property (mode_r.avg && !is_ac
		|-> mode_r.filt == FL_STD || mode_r.filt == FL_TWO)
		else $error("illegal filter under averaging");
	a_ac_filters: assert property (is_ac |-> mode_r.filt == FL_OFF || mode_r.filt == FL_STD)
		else $error("illegal filter in ac volts");
	a_cont_hold: assert property (buf_in && !srst |=> $stable(mode_r))
		else $error("buffered command changed mode");
	a_pend_block: assert property (pend_r |-> !proc)
		else $error("command examined while reading pending");
	a_halt_single: assert property (halt_in_cont |=> left_cont ##1 !mode_r.trig[0])
		else $error("halt did not return to single trigger");
	a_avg_enable: assert property (flush && op_r == OP_O && ndig_r == '0 && !is_ac
		&& !rst_in && !srst |=> mode_r.sample == S_AVG && mode_r.filt == FL_STD)
		else $error("averaging enable preset wrong");
endmodule // mrm_mode_ctrl

// ---- tb/mrm_remote_model.sv ----
// remote controller and reading source model facing the command port
`timescale 1ns/10ps
module mrm_remote_model
	import mrm_pkg::*;
(
	input wire logic clk_i,
	input wire logic cmd_ready_i,
	input wire logic rdg_req_i,
	input wire logic rdg_abort_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_char_o,
	output logic rdg_done_o
);
	int dly = 2;
	int cnt = 0;
	logic pend = 1'b0;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_char_o = 8'h00;
		rdg_done_o = 1'b0;
	end
	// each char held until a rising edge sees ready; released char line toggles
	task automatic send(input string s);
		@(posedge clk_i);
		for (int i = 0; i < s.len(); i++) begin
			cmd_valid_o <= 1'b1;
			cmd_char_o <= s[i];
			do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
		end
		cmd_valid_o <= 1'b0;
		cmd_char_o <= ~cmd_char_o;
	endtask
	// reading answered dly+1 cycles after the request; an abort drops it for good
	always @(posedge clk_i) begin
		rdg_done_o <= 1'b0;
		if (rdg_abort_i === 1'b1) begin
			pend <= 1'b0;
		end else if (rdg_req_i === 1'b1) begin
			pend <= 1'b1;
			cnt <= dly;
		end else if (pend) begin
			if (cnt == 0) begin
				rdg_done_o <= 1'b1;
				pend <= 1'b0;
			end else begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // mrm_remote_model

// ---- tb/meter_remote_mode_control_test.sv ----
// self-checking bench for the remote mode control block
`timescale 1ns/10ps
module meter_remote_mode_control_test
	import mrm_pkg::*;
;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic limit_fail_i = 1'b0;
	logic six_half_i = 1'b0;
	logic [2:0] range_i = 3'h0;
	logic cal_mode_i = 1'b0;
	logic [31:0] prdata_o, rd, rv;
	logic pready_o, pslverr_o, er, gi, zo, cl, sx;
	logic cmd_valid_i, cmd_ready_o, rdg_req_o, rdg_done_i, rdg_abort_o;
	logic [7:0] cmd_char_i, err_resp_char_o;
	logic err_pulse_o, err_resp_prog_o, ascii_d7_zero_o, bin_d8_keep_o;
	logic gain_apply_o, perm_zero_apply_o, tmp_zero_apply_o, tmp_zero_clr_o;
	mrm_mode_s mode_o;
	logic [31:0] seed = 32'h1c;
	int fail_count = 0;
	int tests_run = 0;
	int ab_n = 0;
	int clr_n = 0;
	int ep_n = 0;
	int n, e_s, ee;
	string mc[4] = '{"M\n", "M0\n", "M1\n", "M2\n"};
	string av_c[12] = '{"O\n", "S13\n", "F2\n", "F1\n", "O\n", "S5\n", "O\n", "F3\n", "O\n",
		"O0\n", "O\n", "F0\n"};
	int av_s[12] = '{10, 13, 13, 7, 10, 5, 10, 7, 10, 7, 10, 7};
	mrm_filt_e av_f[12] = '{FL_STD, FL_STD, FL_TWO, FL_ONE, FL_STD, FL_OFF, FL_STD, FL_THREE,
		FL_STD, FL_OFF, FL_STD, FL_OFF};
	logic av_a[12] = '{1, 1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
	string ac_c[11] = '{"VA1\n", "S2\n", "S5\n", "H3\n", "O\n", "F1\n", "F\n", "S0\n", "C2\n",
		"S1\n", "V\n"};
	mrm_func_e ac_fn[11] = '{FN_ACE, FN_ACH, FN_ACH, FN_ACH, FN_ACH, FN_ACH, FN_ACH, FN_ACN,
		FN_ACH, FN_ACE, FN_DCV};
	logic ac_dc[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0};
	mrm_filt_e ac_f[11] = '{FL_OFF, FL_OFF, FL_OFF, FL_OFF, FL_OFF, FL_OFF, FL_STD, FL_STD,
		FL_STD, FL_STD, FL_STD};
	logic ac_a[11] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 0};
	int ac_e[11] = '{0, 0, 9, 9, 0, 9, 0, 0, 0, 0, 0};

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (rdg_abort_o === 1'b1) ab_n++;
		if (tmp_zero_clr_o === 1'b1) clr_n++;
		if (err_pulse_o === 1'b1) ep_n++;
	end

	mrm_mode_ctrl mrm_mode_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.cmd_valid_i(cmd_valid_i), .cmd_char_i(cmd_char_i), .cmd_ready_o(cmd_ready_o),
		.rdg_req_o(rdg_req_o), .rdg_done_i(rdg_done_i), .rdg_abort_o(rdg_abort_o),
		.limit_fail_i(limit_fail_i), .six_half_i(six_half_i), .range_i(range_i),
		.cal_mode_i(cal_mode_i), .mode_o(mode_o), .err_pulse_o(err_pulse_o),
		.err_resp_prog_o(err_resp_prog_o), .err_resp_char_o(err_resp_char_o),
		.ascii_d7_zero_o(ascii_d7_zero_o), .bin_d8_keep_o(bin_d8_keep_o),
		.gain_apply_o(gain_apply_o), .perm_zero_apply_o(perm_zero_apply_o),
		.tmp_zero_apply_o(tmp_zero_apply_o), .tmp_zero_clr_o(tmp_zero_clr_o));
	mrm_remote_model m (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o), .rdg_req_i(rdg_req_o),
		.rdg_abort_i(rdg_abort_o), .cmd_valid_o(cmd_valid_i), .cmd_char_o(cmd_char_i),
		.rdg_done_o(rdg_done_i));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// answer taken at the rising edge that sees pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic pulse_fail();
		@(posedge clk_i);
		limit_fail_i <= 1'b1;
		@(posedge clk_i);
		limit_fail_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_i);
		fail_count++;
		report_and_stop();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("reset_mode", MODE_RST, mode_o);
		chk("reset_gain", 1'b1, gain_apply_o);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped", 1'b1, er);
		apb(1'b0, OFS_STAT, 32'h0);
		chk("stat", MODE_RST, rd);
		e_s = 7;
		for (int i = 0; i < 8; i++) begin
			n = (i > 5) ? 11 + i : rnd() % 20;
			m.send($sformatf("S%0d\n", n));
			ee = (n > 17) ? ERR_CMD : ERR_NONE;
			if (n <= 17) e_s = n;
			@(negedge clk_i);
			chk("sample", e_s, mode_o.sample);
			apb(1'b0, OFS_ERR, 32'h0);
			chk("s_err", ee, rd);
			apb(1'b1, OFS_ERR, 32'h0);
		end
		for (int d = 0; d < 10; d++) begin
			m.send($sformatf("H%0d\n", d));
			@(negedge clk_i);
			chk("h_sample", H_BASE + d, mode_o.sample);
		end
		for (int i = 0; i < 12; i++) begin
			m.send(av_c[i]);
			@(negedge clk_i);
			chk("avg", {5'(av_s[i]), av_f[i], av_a[i]}, {mode_o.sample, mode_o.filt, mode_o.avg});
		end
		// ac entry always by the full function command
		for (int i = 0; i < 11; i++) begin
			ep_n = 0;
			m.send(ac_c[i]);
			@(negedge clk_i);
			chk("ac", {ac_fn[i], S_DEF, ac_f[i], ac_a[i]}, {mode_o.func, mode_o.sample, mode_o.filt, mode_o.avg});
			if (ac_fn[i][2]) chk("ac_cpl", ac_dc[i], mode_o.dc_cpl);
			apb(1'b0, OFS_ERR, 32'h0);
			chk("ac_err", ac_e[i], rd);
			chk("ac_pulse", ac_e[i] != 0, ep_n);
			apb(1'b1, OFS_ERR, 32'h0);
		end
		m.dly = 3;
		m.send("T1\n");
		@(negedge clk_i);
		chk("trig", TRG_CONT_ALT, mode_o.trig);
		m.send("S3\n");
		repeat (4) @(negedge clk_i);
		chk("buffered", S_DEF, mode_o.sample);
		m.send("%");
		repeat (12) @(negedge clk_i);
		chk("halt", {TRG_SGL_ALT, 5'h03}, {mode_o.trig, mode_o.sample});
		m.send("T\n");
		clr_n = 0;
		m.send("*");
		repeat (3) @(negedge clk_i);
		chk("star", MODE_RST, mode_o);
		chk("tmp_clr", 1'b1, clr_n > 0);
		m.dly = 40;
		m.send("?");
		fork
			m.send("S4\n");
			begin
				repeat (20) @(negedge clk_i);
				chk("pending", S_DEF, mode_o.sample);
			end
		join
		@(negedge clk_i);
		chk("after", 5'h04, mode_o.sample);
		ab_n = 0;
		m.send("?");
		m.send("%");
		repeat (5) @(negedge clk_i);
		chk("abort", 1, ab_n);
		pulse_fail();
		chk("resp", {1'b0, CH_TWO}, {err_resp_prog_o, err_resp_char_o});
		m.send("K3\n");
		pulse_fail();
		chk("resp_prog", 1'b1, err_resp_prog_o);
		gi = 1'b0;
		zo = 1'b1;
		for (int i = 0; i < 12; i++) begin
			rv = rnd();
			cl = (i % 8 == 2) ? 1'b1 : rv[0];
			sx = rv[1];
			@(posedge clk_i);
			range_i <= 3'(i % 8);
			cal_mode_i <= cl;
			six_half_i <= sx;
			m.send(mc[i % 4]);
			if (i % 4 < 2) gi = (i % 4 == 0);
			else zo = (i % 4 == 3);
			@(posedge clk_i);
			@(negedge clk_i);
			chk("corr", {!gi, !cl | zo, !cl & zo, (i % 8 == 2) & cl, !sx}, {gain_apply_o, perm_zero_apply_o, tmp_zero_apply_o, bin_d8_keep_o, ascii_d7_zero_o});
		end
		apb(1'b1, OFS_CTRL, 32'h0);
		@(negedge clk_i);
		chk("disabled", 1'b0, cmd_ready_o);
		apb(1'b1, OFS_CTRL, 32'h1);
		m.send("S5\n");
		clr_n = 0;
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (3) @(negedge clk_i);
		chk("soft_rst", MODE_RST, mode_o);
		chk("srst_clr", 1'b1, clr_n > 0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("srst_self_clr", 32'h1, rd);
		report_and_stop();
	end
endmodule // meter_remote_mode_control_test
